// [logic/fls_bus_cycle.sv]
// One asynchronous write or read cycle on the flash pins.
`timescale 1ns/10ps
module fls_bus_cycle (
    input  wire logic                        ref_clk,
    input  wire logic                        srst,
    input  wire logic                        start,
    input  wire logic                        rd,
    input  wire logic [fls_pkg::ADDR_W-1:0]  addr,
    input  wire logic [fls_pkg::DATA_W-1:0]  wdata,
    input  wire logic [fls_pkg::DATA_W-1:0]  dq_i,
    output fls_pkg::fls_pins_t               pins,
    output logic                             idle,
    output logic                             done,
    output logic [fls_pkg::DATA_W-1:0]       rdata
);

    logic                      busy_q;
    logic                      rd_q;
    logic [3:0]                cnt_q;
    fls_pkg::fls_pins_t        pins_q;
    logic [fls_pkg::DATA_W-1:0] rdata_q;
    wire  [3:0]                strobe_last = rd_q ? fls_pkg::ACC_LAST : fls_pkg::WE_LAST;
    wire  [3:0]                total_last  = strobe_last + fls_pkg::REC_CYC;

    assign pins  = pins_q;
    assign idle  = !busy_q;
    assign done  = busy_q && (cnt_q == total_last);
    assign rdata = rdata_q;

    // ------------------------------------------------------------------
    // Strobe sequencing; data is held through recovery for hold time.
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            busy_q  <= 1'b0;
            rd_q    <= 1'b0;
            cnt_q   <= 4'h0;
            rdata_q <= 8'h00;
            pins_q  <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq_o: 8'h00,
                         dq_oe: 1'b0};
        end
        else if (start && !busy_q)
        begin
            busy_q       <= 1'b1;
            rd_q         <= rd;
            cnt_q        <= 4'h0;
            pins_q.ce_n  <= 1'b0;
            pins_q.we_n  <= rd;
            pins_q.oe_n  <= !rd;
            pins_q.addr  <= addr;
            pins_q.dq_o  <= wdata;
            pins_q.dq_oe <= !rd;
        end
        else if (busy_q)
        begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == strobe_last)
            begin
                pins_q.ce_n <= 1'b1;
                pins_q.we_n <= 1'b1;
                pins_q.oe_n <= 1'b1;
                if (rd_q)
                begin
                    rdata_q <= dq_i;
                end
            end
            if (cnt_q == total_last)
            begin
                busy_q       <= 1'b0;
                pins_q.dq_oe <= 1'b0;
            end
        end
    end

endmodule : fls_bus_cycle

// [logic/fls_lock_host.sv]
// Host controller that sets and clears flash lock-bits through the pins.
`timescale 1ns/10ps
module fls_lock_host (
    input  wire logic                        ref_clk,
    input  wire logic                        srst,
    input  wire logic                        req_valid,
    input  fls_pkg::fls_req_t                req,
    output logic                             req_ready,
    output logic                             done,
    output fls_pkg::fls_res_t                result,
    output logic                             lock_undefined,
    output fls_pkg::fls_pins_t               flash_pins,
    input  wire logic [fls_pkg::DATA_W-1:0]  flash_dq_i,
    input  wire logic                        ready_busy_output,
    input  wire logic                        protect_pin_mid,
    output logic                             protect_override_en
);

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] conf_code(input fls_pkg::fls_op_t op);
        unique case (op)
            fls_pkg::FLS_OP_SET_BLOCK:  conf_code = fls_pkg::CMD_BLOCK_CONF;
            fls_pkg::FLS_OP_SET_MASTER: conf_code = fls_pkg::CMD_MASTER_CONF;
            default:                    conf_code = fls_pkg::CMD_CLEAR_CONF;
        endcase
    endfunction : conf_code

    function automatic logic any_err(input logic [7:0] st);
        any_err = st[fls_pkg::LOCKCLEAR_ERR_BIT] | st[fls_pkg::LOCKSET_ERR_BIT]
                | st[fls_pkg::SUPPLY_LOW_BIT] | st[fls_pkg::DEVICE_PROTECT_BIT];
    endfunction : any_err

    function automatic logic op_err(input fls_pkg::fls_op_t op, input logic [7:0] st);
        op_err = (op == fls_pkg::FLS_OP_CLEAR) ? st[fls_pkg::LOCKCLEAR_ERR_BIT]
                                                : st[fls_pkg::LOCKSET_ERR_BIT];
    endfunction : op_err

    // ------------------------------------------------------------------
    // State and storage
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_WAIT_PIN = 3'b001,
        ST_SETUP   = 3'b011,
        ST_CONF    = 3'b010,
        ST_POLL    = 3'b110,
        ST_CLRST   = 3'b111,
        ST_ARRAY   = 3'b101,
        ST_DONE    = 3'b100
    } fls_state_t;

    fls_state_t                 state_q;
    fls_state_t                 state_d;
    fls_pkg::fls_req_t          req_q;
    fls_pkg::fls_res_t          result_q;
    logic                       pend_q;
    logic                       done_q;
    logic                       undef_q;
    logic                       override_q;
    logic                       bus_idle;
    logic                       bus_done;
    logic [fls_pkg::DATA_W-1:0] bus_rdata;

    wire is_write  = (state_q == ST_SETUP) || (state_q == ST_CONF)
                   || (state_q == ST_CLRST) || (state_q == ST_ARRAY);
    wire poll_ok   = (state_q == ST_POLL) && ready_busy_output;
    wire bus_start = (is_write || poll_ok) && !pend_q && bus_idle;
    wire bus_rd    = (state_q == ST_POLL);
    wire st_ready  = bus_rdata[fls_pkg::MACHINE_READY_BIT];
    wire poll_end  = (state_q == ST_POLL) && bus_done && st_ready;
    wire [7:0] bus_wdata =
        (state_q == ST_SETUP) ? fls_pkg::CMD_LOCK_SETUP :
        (state_q == ST_CONF)  ? conf_code(req_q.op) :
        (state_q == ST_CLRST) ? fls_pkg::CMD_CLEAR_STATUS :
                                fls_pkg::CMD_READ_ARRAY;

    assign req_ready      = (state_q == ST_IDLE);
    assign done           = done_q;
    assign result         = result_q;
    assign lock_undefined = undef_q;
    assign protect_override_en = override_q;

    fls_bus_cycle fls_bus_cycle_i (
        .ref_clk (ref_clk),
        .srst    (srst),
        .start   (bus_start),
        .rd      (bus_rd),
        .addr    (req_q.addr),
        .wdata   (bus_wdata),
        .dq_i    (flash_dq_i),
        .pins    (flash_pins),
        .idle    (bus_idle),
        .done    (bus_done),
        .rdata   (bus_rdata)
    );

    // ------------------------------------------------------------------
    // Sequence control
    // ------------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:     if (req_valid) state_d = ST_WAIT_PIN;
            ST_WAIT_PIN: if (!protect_pin_mid) state_d = ST_SETUP;
            ST_SETUP:   if (bus_done) state_d = ST_CONF;
            ST_CONF:    if (bus_done) state_d = ST_POLL;
            ST_POLL:    if (poll_end) state_d = any_err(bus_rdata) ? ST_CLRST : ST_ARRAY;
            ST_CLRST:   if (bus_done) state_d = ST_ARRAY;
            ST_ARRAY:   if (bus_done) state_d = ST_DONE;
            ST_DONE:    state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            state_q <= ST_IDLE;
            pend_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            pend_q  <= bus_done ? 1'b0 : (pend_q | bus_start);
        end
    end

    // ------------------------------------------------------------------
    // Request capture, override drive and result reporting
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            req_q      <= '{op: fls_pkg::FLS_OP_SET_BLOCK, addr: '0, override: 1'b0};
            override_q <= 1'b0;
        end
        else if (req_valid && req_ready)
        begin
            req_q      <= req;
            override_q <= req.override;
        end
        else if (state_q == ST_DONE)
        begin
            override_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            result_q <= '0;
            done_q   <= 1'b0;
            undef_q  <= 1'b0;
        end
        else
        begin
            done_q <= (state_q == ST_ARRAY) && bus_done;
            if (poll_end)
            begin
                result_q.machine_ready_flag         <= 1'b1;
                result_q.erase_lockclear_error_flag <= bus_rdata[fls_pkg::LOCKCLEAR_ERR_BIT];
                result_q.write_lockset_error_flag   <= bus_rdata[fls_pkg::LOCKSET_ERR_BIT];
                result_q.supply_low_flag            <= bus_rdata[fls_pkg::SUPPLY_LOW_BIT];
                result_q.device_protect_flag        <= bus_rdata[fls_pkg::DEVICE_PROTECT_BIT];
                result_q.op_failed                  <= op_err(req_q.op, bus_rdata);
                if (req_q.op == fls_pkg::FLS_OP_CLEAR)
                begin
                    undef_q <= bus_rdata[fls_pkg::LOCKCLEAR_ERR_BIT];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence s_setup_done;
        (state_q == ST_SETUP) && bus_done;
    endsequence
    sequence s_confirm_issued;
        ##[1:2] (state_q == ST_CONF) && bus_start && (bus_wdata == conf_code(req_q.op));
    endsequence

    setup_code_a: assert property ((state_q == ST_SETUP) && bus_start |->
        bus_wdata == 8'h60) else $error("lock setup code not 60h");
    two_write_a: assert property (s_setup_done |-> s_confirm_issued)
        else $error("confirm write did not follow setup");
    poll_wait_a: assert property ((state_q == ST_POLL) && !ready_busy_output |->
        !bus_start) else $error("status read issued while device busy");
    result_ready_a: assert property (done_q |-> result_q.machine_ready_flag)
        else $error("result reported before machine ready");
    clear_status_a: assert property (poll_end && any_err(bus_rdata) |=>
        (state_q == ST_CLRST) ##[0:3] bus_start && (bus_wdata == 8'h50))
        else $error("clear status not issued after error");
    array_end_a: assert property ((state_q == ST_ARRAY) && bus_start |->
        (bus_wdata == 8'hff) ##[1:12] done_q) else $error("read array not written at end");
    mid_level_a: assert property ((state_q == ST_WAIT_PIN) && protect_pin_mid |=>
        (state_q == ST_WAIT_PIN) && !flash_pins.dq_oe) else $error("write while protect mid");
    override_hold_a: assert property (((state_q == ST_SETUP) || (state_q == ST_CONF)
        || (state_q == ST_POLL)) && req_q.override |-> protect_override_en)
        else $error("override dropped during operation");
    undef_flag_a: assert property (poll_end && (req_q.op == fls_pkg::FLS_OP_CLEAR)
        |=> lock_undefined == $past(bus_rdata[5])) else $error("undefined flag wrong");
    op_fail_a: assert property (poll_end && (req_q.op != fls_pkg::FLS_OP_CLEAR) |=>
        result_q.op_failed == $past(bus_rdata[4])) else $error("set failure misreported");

endmodule : fls_lock_host

// [logic/fls_pkg.sv]
// Shared constants and types for the lock-bit command controller.
package fls_pkg;

    // ------------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------------
    localparam int ADDR_W        = 20;
    localparam int DATA_W        = 8;
    localparam int CLK_PERIOD_NS = 20;
    localparam int T_WE_NS       = 50;
    localparam int T_ACC_NS      = 85;
    localparam int T_REC_NS      = 20;
    localparam int T_WE_CYC      = (T_WE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_ACC_CYC     = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_REC_CYC     = (T_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] WE_LAST  = 4'(T_WE_CYC - 1);
    localparam logic [3:0] ACC_LAST = 4'(T_ACC_CYC - 1);
    localparam logic [3:0] REC_CYC  = 4'(T_REC_CYC);

    // ------------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_LOCK_SETUP   = 8'h60;
    localparam logic [7:0] CMD_BLOCK_CONF   = 8'h01;
    localparam logic [7:0] CMD_MASTER_CONF  = 8'hf1;
    localparam logic [7:0] CMD_CLEAR_CONF   = 8'hd0;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;

    // ------------------------------------------------------------------
    // Status byte bit positions
    // ------------------------------------------------------------------
    localparam int MACHINE_READY_BIT  = 7;
    localparam int LOCKCLEAR_ERR_BIT  = 5;
    localparam int LOCKSET_ERR_BIT    = 4;
    localparam int SUPPLY_LOW_BIT     = 3;
    localparam int DEVICE_PROTECT_BIT = 1;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        FLS_OP_SET_BLOCK  = 2'h0,
        FLS_OP_SET_MASTER = 2'h1,
        FLS_OP_CLEAR      = 2'h2
    } fls_op_t;

    typedef struct packed {
        fls_op_t             op;
        logic [ADDR_W-1:0]   addr;
        logic                override;
    } fls_req_t;

    typedef struct packed {
        logic                machine_ready_flag;
        logic                erase_lockclear_error_flag;
        logic                write_lockset_error_flag;
        logic                supply_low_flag;
        logic                device_protect_flag;
        logic                op_failed;
    } fls_res_t;

    typedef struct packed {
        logic                ce_n;
        logic                oe_n;
        logic                we_n;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   dq_o;
        logic                dq_oe;
    } fls_pins_t;

endpackage : fls_pkg

// [testbench/fls_dev_model.sv]
// Behavioural flash device that answers lock-bit command sequences on the pins.
`timescale 1ns/10ps
module fls_dev_model #(
    parameter int BUSY_CYC = 12
) (
    input  wire logic          ref_clk,
    input  fls_pkg::fls_pins_t pins,
    input  wire logic          protect_override_en,
    input  wire logic          vpp_low,
    input  wire logic          bad_seq,
    output logic [7:0]         dq,
    output logic               ready_busy_output,
    output logic               protect_pin_mid
);
    // ------------------------------------------------------------------
    // Device state
    // ------------------------------------------------------------------
    logic [15:0] block_lock_q = '0;
    logic        master_q     = 1'b0;
    logic [7:0]  sr_q         = 8'h80;
    logic [7:0]  pend_q       = 8'h00;
    logic [7:0]  cmd_q        = 8'h00;
    logic        setup_q      = 1'b0;
    logic        status_q     = 1'b0;
    logic        we_prev_q    = 1'b1;
    logic        ovr_prev_q   = 1'b0;
    logic [3:0]  blk_q        = 4'h0;
    logic [1:0]  mid_q        = 2'h0;
    logic [2:0]  acc_q        = 3'h0;
    logic [7:0]  last_q       = 8'h00;
    int          busy_q       = 0;
    wire         rd_active    = (pins.ce_n === 1'b0) && (pins.oe_n === 1'b0);
    wire         we_rise      = (we_prev_q === 1'b0) && (pins.we_n === 1'b1);
    // While busy the low status bits carry junk, so only the ready bit means anything.
    wire  [7:0]  status_byte  = (busy_q != 0) ? {1'b0, ~last_q[6:0]} : sr_q;

    assign ready_busy_output = (busy_q == 0);
    // The pin leaves its level in the very cycle the override request changes.
    assign protect_pin_mid   = (mid_q != 2'h0) || (protect_override_en !== ovr_prev_q);
    // A released bus shows a pattern that changes every cycle.
    assign dq = (rd_active && acc_q >= 3'h2) ? (status_q ? status_byte : 8'hff) : ~last_q;

    // ------------------------------------------------------------------
    // Outcome of a confirm write
    // ------------------------------------------------------------------
    function automatic logic [7:0] outcome(input logic [7:0] d);
        outcome = 8'h00;
        if (bad_seq || !(d == 8'h01 || d == 8'hf1 || d == 8'hd0))
            outcome = 8'h30;
        else if (vpp_low)
            outcome = (d == 8'hd0) ? 8'h28 : 8'h18;
        else if (d == 8'hf1 && !protect_override_en)
            outcome = 8'h12;
        else if (d != 8'hf1 && master_q && !protect_override_en)
            outcome = (d == 8'hd0) ? 8'h22 : 8'h12;
    endfunction : outcome

    // ------------------------------------------------------------------
    // Command interface and lock algorithm
    // ------------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        we_prev_q  <= pins.we_n;
        ovr_prev_q <= protect_override_en;
        last_q     <= dq;
        acc_q      <= rd_active ? ((acc_q == 3'h7) ? acc_q : acc_q + 3'h1) : 3'h0;
        if (protect_override_en !== ovr_prev_q)
            mid_q <= 2'h3;
        else if (mid_q != 2'h0)
            mid_q <= mid_q - 2'h1;
        if (busy_q == 1)
        begin
            sr_q <= sr_q | pend_q | 8'h80;
            if (pend_q == 8'h00 && cmd_q == 8'h01)
                block_lock_q[blk_q] <= 1'b1;
            if (pend_q == 8'h00 && cmd_q == 8'hf1)
                master_q <= 1'b1;
            if (pend_q == 8'h00 && cmd_q == 8'hd0)
                block_lock_q <= '0;
        end
        if (busy_q != 0)
            busy_q <= busy_q - 1;
        else if (we_rise && setup_q)
        begin
            setup_q  <= 1'b0;
            status_q <= 1'b1;
            cmd_q    <= pins.dq_o;
            blk_q    <= pins.addr[19:16];
            pend_q   <= outcome(pins.dq_o);
            busy_q   <= BUSY_CYC;
            sr_q[7]  <= 1'b0;
        end
        else if (we_rise && pins.dq_o == 8'h60)
            setup_q <= 1'b1;
        else if (we_rise && pins.dq_o == 8'h50)
            sr_q <= 8'h80;
        else if (we_rise && pins.dq_o == 8'hff)
            status_q <= 1'b0;
    end
endmodule : fls_dev_model

// [testbench/tb_flash_lock_bit_sequencer.sv]
// Self-checking testbench for the lock-bit host controller against a device model.
`timescale 1ns/10ps
module tb_flash_lock_bit_sequencer;
    logic                  ref_clk   = 1'b0;
    logic                  srst      = 1'b1;
    logic                  req_valid = 1'b0;
    logic                  vpp_low   = 1'b0;
    logic                  bad_seq   = 1'b0;
    fls_pkg::fls_req_t     req       = '0;
    logic                  req_ready;
    logic                  done;
    logic                  lock_undefined;
    logic                  protect_override_en;
    logic                  ready_busy_output;
    logic                  protect_pin_mid;
    logic [7:0]            flash_dq;
    fls_pkg::fls_res_t     result;
    fls_pkg::fls_pins_t    flash_pins;
    fls_pkg::fls_res_t     exp_q[$];
    logic                  master_sh = 1'b0;
    logic [15:0]           lock_sh   = '0;
    logic                  undef_sh  = 1'b0;
    int                    fails     = 0;
    int                    cmp_count = 0;

    always #10 ref_clk = ~ref_clk;

    fls_lock_host fls_lock_host_i (
        .ref_clk(ref_clk), .srst(srst), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .done(done), .result(result),
        .lock_undefined(lock_undefined), .flash_pins(flash_pins), .flash_dq_i(flash_dq),
        .ready_busy_output(ready_busy_output), .protect_pin_mid(protect_pin_mid),
        .protect_override_en(protect_override_en)
    );

    fls_dev_model fls_dev_model_i (
        .ref_clk(ref_clk), .pins(flash_pins), .protect_override_en(protect_override_en),
        .vpp_low(vpp_low), .bad_seq(bad_seq), .dq(flash_dq),
        .ready_busy_output(ready_busy_output), .protect_pin_mid(protect_pin_mid)
    );

    // ------------------------------------------------------------------
    // Comparison, verdict and result watcher
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    always @(negedge ref_clk)
    begin
        if (done === 1'b1 && exp_q.size() == 0)
            check(32'h1, 32'h0, "done without request");
        else if (done === 1'b1)
            check(32'(result), 32'(exp_q.pop_front()), "result");
    end

    // ------------------------------------------------------------------
    // One lock-bit operation with its expected outcome
    // ------------------------------------------------------------------
    task automatic run_op(input fls_pkg::fls_op_t op, input logic ovr, input string name);
        logic [3:0] blk;
        logic       e5;
        logic       e4;
        logic       e3;
        logic       e1;
        int         n;
        blk = 4'($urandom_range(0, 15));
        {e5, e4, e3, e1} = 4'h0;
        if (bad_seq)
            {e5, e4} = 2'h3;
        else if (vpp_low)
            {e5, e4, e3} = (op == fls_pkg::FLS_OP_CLEAR) ? 3'h5 : 3'h3;
        else if (op == fls_pkg::FLS_OP_SET_MASTER && !ovr)
            {e4, e1} = 2'h3;
        else if (op != fls_pkg::FLS_OP_SET_MASTER && master_sh && !ovr)
            {e5, e4, e1} = (op == fls_pkg::FLS_OP_CLEAR) ? 3'h5 : 3'h3;
        else if (op == fls_pkg::FLS_OP_SET_BLOCK)
            lock_sh[blk] = 1'b1;
        else if (op == fls_pkg::FLS_OP_SET_MASTER)
            master_sh = 1'b1;
        else
            lock_sh = '0;
        if (op == fls_pkg::FLS_OP_CLEAR)
            undef_sh = e5;
        exp_q.push_back({1'b1, e5, e4, e3, e1, (op == fls_pkg::FLS_OP_CLEAR) ? e5 : e4});
        n = 0;
        while (req_ready !== 1'b1 && n < 100)
        begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 100)
        begin
            fails++;
            $display("mismatch at %0t: request not accepted", $time);
            complete_run();
        end
        req       = {op, blk, 16'($urandom), ovr};
        req_valid = 1'b1;
        @(negedge ref_clk);
        req_valid = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 3000)
        begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 3000)
        begin
            fails++;
            $display("mismatch at %0t: no completion", $time);
            complete_run();
        end
        @(negedge ref_clk);
        check(32'(lock_undefined), 32'(undef_sh), "undefined flag");
        check(32'(fls_dev_model_i.block_lock_q), 32'(lock_sh), "block locks");
        check(32'(fls_dev_model_i.master_q), 32'(master_sh), "master lock");
        check(32'(fls_dev_model_i.status_q), 32'h0, "array mode");
        check(32'(fls_dev_model_i.sr_q), 32'h80, "status cleared");
        $display("test %s finished", name);
    endtask : run_op

    // ------------------------------------------------------------------
    // Scenario list
    // ------------------------------------------------------------------
    initial
    begin
        void'($urandom(14));
        repeat (4) @(negedge ref_clk);
        srst = 1'b0;
        run_op(fls_pkg::FLS_OP_SET_BLOCK, 1'b0, "set block unlocked");
        run_op(fls_pkg::FLS_OP_SET_BLOCK, 1'b1, "set block override");
        run_op(fls_pkg::FLS_OP_CLEAR, 1'b0, "clear unlocked");
        run_op(fls_pkg::FLS_OP_SET_MASTER, 1'b0, "master refused");
        run_op(fls_pkg::FLS_OP_SET_BLOCK, 1'b0, "block before master");
        run_op(fls_pkg::FLS_OP_SET_MASTER, 1'b1, "master override");
        run_op(fls_pkg::FLS_OP_SET_BLOCK, 1'b0, "block refused by master");
        run_op(fls_pkg::FLS_OP_CLEAR, 1'b0, "clear refused by master");
        vpp_low = 1'b1;
        run_op(fls_pkg::FLS_OP_CLEAR, 1'b1, "clear low supply");
        run_op(fls_pkg::FLS_OP_SET_BLOCK, 1'b1, "set low supply");
        vpp_low = 1'b0;
        bad_seq = 1'b1;
        run_op(fls_pkg::FLS_OP_SET_MASTER, 1'b1, "bad set sequence");
        run_op(fls_pkg::FLS_OP_CLEAR, 1'b1, "bad clear sequence");
        bad_seq = 1'b0;
        run_op(fls_pkg::FLS_OP_SET_BLOCK, 1'b1, "block with master override");
        run_op(fls_pkg::FLS_OP_CLEAR, 1'b1, "clear with master override");
        complete_run();
    end
endmodule : tb_flash_lock_bit_sequencer
